/* File: include/pmw_regs.vh */
// Constants for the power mode, wake and reset sequencer.
// Contract
// - Device performs full reset once reset input held low for the minimum time.
// - Each wake pin wakes on low level, high level, or any change.
// - Exactly three power states: run, standby doze, deep sleep (lowest power). The sequencer also reports a fourth state, reset, on power_state_o.
// - Enter standby doze when processor waits for event and none are pending.
// - In standby doze, any interrupt, including serial character, returns to run.
// - Waking from deep sleep passes through a complete system reset.
`ifndef PMW_REGS_VH
`define PMW_REGS_VH
`define PMW_RESET_MIN_MS 100
`define PMW_CLK_KHZ 125000
`define PMW_RESET_CYCLES (`PMW_RESET_MIN_MS * `PMW_CLK_KHZ)
`define PMW_SYSRST_CYCLES 16
`define PMW_WAKE_LOW 2'h0
`define PMW_WAKE_HIGH 2'h1
`define PMW_WAKE_CHANGE 2'h2
`define PMW_WAKE_OFF 2'h3
`define PMW_ST_RUN 4'h1
`define PMW_ST_DOZE 4'h2
`define PMW_ST_SLEEP 4'h4
`define PMW_ST_RESET 4'h8
`endif

/* File: logic/pmw_sync.v */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
`default_nettype none
module pmw_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset.
  input wire ref_clk_i,
  input wire rst_n_i,
  // Asynchronous pin and filtered level.
  input wire async_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;

  // The level changes only once the second and third stages agree.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      level_o <= RESET_VAL;
    end
    else
    begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        level_o <= s3;
      end
    end
  end
endmodule // pmw_sync
`default_nettype wire

/* File: logic/pmw_seq.v */
// Power mode sequencer with wake pins and reset-pin timing.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_regs.vh"
module pmw_seq #(
  parameter N_WAKE = 4,
  parameter RESET_CYCLES = `PMW_RESET_CYCLES,
  parameter SYSRST_CYCLES = `PMW_SYSRST_CYCLES
) (
  // Clock and synchronous reset.
  input wire ref_clk_i,
  input wire rst_n_i,
  // External pins.
  input wire hw_reset_in_n_i,
  input wire [N_WAKE-1:0] general_io_pin_i,
  // Wake configuration, two bits per pin.
  input wire [2*N_WAKE-1:0] wake_mode_i,
  // Processor handshake.
  input wire wait_for_event_stmt_i,
  input wire events_pending_i,
  input wire irq_i,
  input wire deep_sleep_req_i,
  // Power state and reset outputs.
  output reg [3:0] power_state_o,
  output reg sys_reset_o,
  output reg wake_o
);
  localparam [31:0] RST_MAX = RESET_CYCLES;
  localparam [31:0] SYS_MAX = SYSRST_CYCLES;

  // ----------------------------------------
  // One-hot state codes.
  // ----------------------------------------
  localparam [3:0] ST_RUN = `PMW_ST_RUN;
  localparam [3:0] ST_DOZE = `PMW_ST_DOZE;
  localparam [3:0] ST_SLEEP = `PMW_ST_SLEEP;
  localparam [3:0] ST_RESET = `PMW_ST_RESET;

  wire rst_pin_lvl;
  wire [N_WAKE-1:0] pin_lvl;
  reg [N_WAKE-1:0] pin_prev;
  reg [N_WAKE-1:0] pin_hit;
  reg [31:0] rst_cnt;
  reg [31:0] sys_cnt;
  reg [3:0] state;
  reg [3:0] next_state;
  reg pin_reset;
  reg any_wake;
  integer k;

  // ----------------------------------------
  // Input synchronisers.
  // ----------------------------------------
  pmw_sync #(.RESET_VAL(1'b1)) u_rst_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(hw_reset_in_n_i),
    .level_o(rst_pin_lvl)
  );

  genvar g;
  generate
    for (g = 0; g < N_WAKE; g = g + 1)
    begin : g_sync
      pmw_sync #(.RESET_VAL(1'b0)) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(general_io_pin_i[g]),
        .level_o(pin_lvl[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Wake pin evaluation.
  // ----------------------------------------
  // Change mode compares the filtered level with its value one cycle earlier.
  always @*
  begin
    pin_hit = {N_WAKE{1'b0}};
    for (k = 0; k < N_WAKE; k = k + 1)
    begin
      case (wake_mode_i[2*k +: 2])
        `PMW_WAKE_LOW: pin_hit[k] = ~pin_lvl[k];
        `PMW_WAKE_HIGH: pin_hit[k] = pin_lvl[k];
        `PMW_WAKE_CHANGE: pin_hit[k] = pin_lvl[k] ^ pin_prev[k];
        default: pin_hit[k] = 1'b0;
      endcase
    end
    any_wake = |pin_hit;
  end

  // ----------------------------------------
  // Previous filtered wake levels.
  // ----------------------------------------
  // Cleared to the idle pin level, so no false change follows reset.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_prev <= {N_WAKE{1'b0}};
    end
    else
    begin
      pin_prev <= pin_lvl;
    end
  end

  // ----------------------------------------
  // Reset pin low-time counter.
  // ----------------------------------------
  // A return of the filtered pin to high restarts the count, so a short
  // low pulse never resets the module.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rst_cnt <= 32'h0;
      pin_reset <= 1'b0;
    end
    else
    begin
      pin_reset <= 1'b0;
      if (rst_pin_lvl)
      begin
        rst_cnt <= 32'h0;
      end
      else if (rst_cnt < RST_MAX - 32'h1)
      begin
        rst_cnt <= rst_cnt + 32'h1;
      end
      else
      begin
        rst_cnt <= 32'h0;
        pin_reset <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Power state machine.
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (deep_sleep_req_i)
        begin
          next_state = ST_SLEEP;
        end
        else if (wait_for_event_stmt_i && !events_pending_i && !irq_i)
        begin
          next_state = ST_DOZE;
        end
      end
      ST_DOZE:
      begin
        if (irq_i || any_wake)
        begin
          next_state = ST_RUN;
        end
      end
      ST_SLEEP:
      begin
        if (any_wake)
        begin
          next_state = ST_RESET;
        end
      end
      ST_RESET:
      begin
        if (sys_cnt >= SYS_MAX - 32'h1)
        begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RESET;
    endcase
    if (pin_reset)
    begin
      next_state = ST_RESET;
    end
  end

  // ----------------------------------------
  // State register and reset hold counter.
  // ----------------------------------------
  // The hold count restarts on each entry into reset and again when the pin
  // fires while already in reset, so every system reset runs in full.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_RESET;
      sys_cnt <= 32'h0;
    end
    else
    begin
      state <= next_state;
      if (next_state == ST_RESET && (state != ST_RESET || pin_reset))
      begin
        sys_cnt <= 32'h0;
      end
      else if (state == ST_RESET)
      begin
        sys_cnt <= sys_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Output registers.
  // ----------------------------------------
  // Outputs follow the next state, so they change together with the state.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      power_state_o <= ST_RESET;
      sys_reset_o <= 1'b1;
      wake_o <= 1'b0;
    end
    else
    begin
      power_state_o <= next_state;
      sys_reset_o <= (next_state == ST_RESET);
      wake_o <= (state != ST_RUN) && (next_state == ST_RUN);
    end
  end
endmodule // pmw_seq
`default_nettype wire

/* File: tb/pmw_seq_sva.sv */
// Port assertions for the power mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module pmw_seq_sva #(parameter N_WAKE = 4) (
  input wire logic ref_clk_i, rst_n_i, hw_reset_in_n_i, wait_for_event_stmt_i,
  input wire logic events_pending_i, irq_i, deep_sleep_req_i, sys_reset_o, wake_o,
  input wire logic [N_WAKE-1:0] general_io_pin_i,
  input wire logic [2*N_WAKE-1:0] wake_mode_i,
  input wire logic [3:0] power_state_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_state_onehot: assert property ($onehot(power_state_o)) else $error("state");
  a_reset_level: assert property (sys_reset_o == power_state_o[3]) else $error("rst");
  a_doze_entry: assert property (power_state_o[0] && wait_for_event_stmt_i && !irq_i
    && !events_pending_i && !deep_sleep_req_i && hw_reset_in_n_i |=> power_state_o[1])
    else $error("doze");
  a_doze_exit: assert property (power_state_o[1] && irq_i |=> power_state_o[0] && wake_o)
    else $error("exit");
  a_sleep_reset: assert property (power_state_o[2] ##1 !power_state_o[2] |-> sys_reset_o)
    else $error("sleep");
  a_wake_pulse: assert property (wake_o |-> power_state_o[0] && !$past(power_state_o[0]))
    else $error("wake");
  a_sync_delay: assert property (power_state_o[2] && $changed(general_io_pin_i)
    |=> power_state_o[2]) else $error("sync");
endmodule // pmw_seq_sva
bind pmw_seq pmw_seq_sva #(.N_WAKE(N_WAKE)) u_sva (.ref_clk_i, .rst_n_i, .hw_reset_in_n_i,
  .wait_for_event_stmt_i, .events_pending_i, .irq_i, .deep_sleep_req_i, .sys_reset_o,
  .wake_o, .general_io_pin_i, .wake_mode_i, .power_state_o);
`default_nettype wire

/* File: tb/pmw_host.sv */
// Host model driving the reset pin and the wake pins.
`timescale 1ns/10ps
`default_nettype none
module pmw_host (
  // Clock.
  input wire logic clk_i,
  // Pins.
  output var logic rst_pin_n_o,
  output var logic [3:0] pin_o
);
  initial rst_pin_n_o = 1'b1;
  initial pin_o = 4'h0;
  task automatic hold_reset(input int n);
    @(posedge clk_i);
    #1 rst_pin_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 rst_pin_n_o = 1'b1;
  endtask
  task automatic set_pin(input logic [3:0] v);
    @(posedge clk_i);
    #1 pin_o = v;
  endtask
endmodule // pmw_host
`default_nettype wire

/* File: tb/pmw_seq_tb.sv */
// Testbench for the power mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module pmw_seq_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wfe = 1'b0;
  logic pend = 1'b0;
  logic irq = 1'b0;
  logic dsr = 1'b0;
  logic [7:0] mode = 8'hff;
  logic pin_n, wake, sysr;
  logic [3:0] pins, st;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  pmw_host host (.clk_i(ref_clk_i), .rst_pin_n_o(pin_n), .pin_o(pins));
  pmw_seq #(.RESET_CYCLES(20), .SYSRST_CYCLES(4)) dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .hw_reset_in_n_i(pin_n), .general_io_pin_i(pins), .wake_mode_i(mode),
    .wait_for_event_stmt_i(wfe), .events_pending_i(pend), .irq_i(irq), .deep_sleep_req_i(dsr),
    .power_state_o(st), .sys_reset_o(sysr), .wake_o(wake));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_st(input logic [3:0] s);
    for (int i = 0; i < 60 && st !== s; i++) tick(1);
    chk(st, s);
  endtask
  task automatic t_doze;
    wfe = 1'b1;
    pend = 1'b1;
    tick(2);
    chk(st, 4'h1);
    pend = 1'b0;
    tick(1);
    chk(st, 4'h2);
    irq = 1'b1;
    tick(1);
    chk({wake, st[2:0]}, 4'h9);
    irq = 1'b0;
    mode = 8'hfd;
    tick(1);
    chk(st, 4'h2);
    host.set_pin(4'h1);
    wait_st(4'h1);
    chk({3'h0, wake}, 4'h1);
    wfe = 1'b0;
    mode = 8'hff;
    $display("test doze done");
  endtask
  task automatic t_sleep;
    for (int m = 0; m < 3; m++)
    begin
      host.set_pin({3'h0, m == 0});
      tick(6);
      mode = {6'h3f, m[1:0]};
      dsr = 1'b1;
      irq = 1'b1;
      tick(1);
      dsr = 1'b0;
      tick(3);
      chk(st, 4'h4);
      irq = 1'b0;
      host.set_pin({3'h0, m != 0});
      wait_st(4'h8);
      chk({sysr, st[2:0]}, 4'h8);
      wait_st(4'h1);
      mode = 8'hff;
    end
    $display("test sleep done");
  endtask
  task automatic t_pin;
    host.hold_reset(12);
    tick(8);
    chk(st, 4'h1);
    host.hold_reset(22);
    wait_st(4'h8);
    chk({sysr, st[2:0]}, 4'h8);
    wait_st(4'h1);
    $display("test reset pin done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      wrap_up;
    end
  end
  initial
  begin
    tick(6);
    chk(st, 4'h8);
    rst_n_i = 1'b1;
    wait_st(4'h1);
    t_doze;
    t_sleep;
    t_pin;
    wrap_up;
  end
endmodule // pmw_seq_tb
`default_nettype wire
